// [common/sbc_supervisor_pkg.sv]
// Constants, types and register map of the fault and watchdog supervisor
package sbc_supervisor_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_TIME_MS    = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int SWE_TIME_MS     = 1000;
  localparam int COLD_RST_MS     = 20;
  localparam int WARM_RST_MS     = 10;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MODE    = 8'h01;
  localparam logic [7:0] IDX_WD_CFG1 = 8'h13;
  localparam logic [7:0] IDX_WD_CFG2 = 8'h14;
  localparam logic [7:0] IDX_WD_TRIG = 8'h15;
  localparam logic [7:0] IDX_INT1    = 8'h51;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_EN_BIT   = 7;
  localparam int MODE_CUR_LSB  = 4;
  localparam int MODE_TSD_BIT  = 3;
  localparam int WD_TYPE_LSB   = 6;
  localparam int WD_PRE_LSB    = 4;
  localparam int WD_CNT_LSB    = 2;
  localparam int WD_TIMER_LSB  = 5;
  localparam int WD_THR_LSB    = 0;
  localparam int WAKE_ERROR_FLAG_BIT     = 4;
  localparam logic [7:0] TRIG_KEY  = 8'hA5;
  localparam logic [7:0] SYNC_RST  = 8'h0D;

  typedef enum logic [2:0] {
    MODE_RESET    = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_SILENT   = 3'b010,
    MODE_STANDBY  = 3'b011,
    MODE_FAILSAFE = 3'b100
  } opMode_t;

  typedef enum logic [1:0] {
    WD_AUTO    = 2'b00,
    WD_TIMEOUT = 2'b01,
    WD_WINDOW  = 2'b10,
    WD_QA      = 2'b11
  } wdType_t;

  typedef struct packed {
    logic overTemp;
    logic tempBelow;
    logic underVolt;
    logic overVolt;
  } faultPins_t;

  typedef struct packed {
    logic       enable;
    wdType_t    wdType;
    logic [1:0] pre;
    logic [2:0] timer;
    logic [1:0] thr;
  } wdCfg_t;

  localparam wdCfg_t WD_CFG_RST = '{1'b0, WD_AUTO, 2'b00, 3'b000, 2'b00};

endpackage

// [rtl/sbc_fault_watchdog_supervisor.sv]
// Fault-driven mode control, sleep-wake error timer and watchdog core
`timescale 1ns/1ns
module sbc_fault_watchdog_supervisor
#(
  parameter int TICK_CYCLES = sbc_supervisor_pkg::TICK_CYCLES
)
(
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [31:0]                         hrdata,
  output logic                                hresp,
  input  wire sbc_supervisor_pkg::faultPins_t faultPins,
  input  wire logic                           txdPin,
  input  wire logic                           serialSelectNPin,
  input  wire logic                           sclkPin,
  input  wire logic                           canRxPin,
  output logic                                txdToCore,
  output logic                                serialSelectN,
  output logic                                sclkToCore,
  output logic                                txEnable,
  output logic                                rxEnable,
  output logic                                rxdOut,
  output logic                                resetOutLow,
  output logic                                resetOutOeN,
  output sbc_supervisor_pkg::opMode_t         opMode
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] syncMeta;
  logic [7:0] syncPins;
  // Safe levels until real samples arrive
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      syncMeta <= sbc_supervisor_pkg::SYNC_RST;
      syncPins <= sbc_supervisor_pkg::SYNC_RST;
    end
    else
    begin
      syncMeta <= {faultPins, txdPin, serialSelectNPin, sclkPin, canRxPin};
      syncPins <= syncMeta;
    end

  wire overTemp  = syncPins[7];
  wire tempBelow = syncPins[6];
  wire underVolt = syncPins[5];
  wire overVolt  = syncPins[4];
  wire canRx     = syncPins[0];
  assign txdToCore     = syncPins[3];
  assign serialSelectN = syncPins[2];
  assign sclkToCore    = syncPins[1];

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [15:0] tickCnt;
  logic        msTick;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tickCnt <= 16'h0000;
      msTick  <= 1'b0;
    end
    else
    begin
      msTick  <= (tickCnt == 16'(TICK_CYCLES - 1));
      tickCnt <= (tickCnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tickCnt + 16'h0001;
    end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        dWrite;
  logic        dRead;
  logic [7:0]  dIdx;
  logic        dOk;
  logic [31:0] rdMux;
  wire accept  = hsel & htrans[1] & hready;
  wire addrOk  = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
  wire wrEn    = dWrite & dOk;
  wire wrMode  = wrEn && (dIdx == sbc_supervisor_pkg::IDX_MODE);
  wire wrCfg1  = wrEn && (dIdx == sbc_supervisor_pkg::IDX_WD_CFG1);
  wire wrCfg2  = wrEn && (dIdx == sbc_supervisor_pkg::IDX_WD_CFG2);
  wire wrTrig  = wrEn && (dIdx == sbc_supervisor_pkg::IDX_WD_TRIG);
  wire wrInt1  = wrEn && (dIdx == sbc_supervisor_pkg::IDX_INT1);

  // Reads wait one cycle so that a write in the previous data phase is seen
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      dWrite    <= 1'b0;
      dRead     <= 1'b0;
      dIdx      <= 8'h00;
      dOk       <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else
    begin
      dWrite <= accept & hwrite;
      dRead  <= accept & ~hwrite;
      if (accept)
      begin
        dIdx <= haddr[9:2];
        dOk  <= addrOk;
      end
      hreadyout <= ~(accept & ~hwrite);
      if (dRead)
        hrdata <= rdMux;
    end

  // ----------------------------------------------------------------
  // Fault handling and operating mode
  // ----------------------------------------------------------------
  sbc_supervisor_pkg::opMode_t mode;
  sbc_supervisor_pkg::opMode_t reqMode;
  sbc_supervisor_pkg::opMode_t next_mode;
  logic        tsdLatch;
  logic [15:0] rstCnt;
  logic        wdError;

  wire sbc_supervisor_pkg::opMode_t wrMode_t = sbc_supervisor_pkg::opMode_t'({1'b0, hwdata[1:0]});
  wire failsafeCause = tsdLatch | overTemp | overVolt;
  wire modeChange    = (next_mode != mode);
  wire inStandby     = (mode == sbc_supervisor_pkg::MODE_STANDBY);
  wire runMode       = (mode == sbc_supervisor_pkg::MODE_NORMAL) || (mode == sbc_supervisor_pkg::MODE_SILENT)
                       || inStandby;

  always_comb
  begin
    next_mode = mode;
    if (underVolt)
      next_mode = sbc_supervisor_pkg::MODE_RESET;
    else if (failsafeCause)
      next_mode = sbc_supervisor_pkg::MODE_FAILSAFE;
    else if (mode == sbc_supervisor_pkg::MODE_FAILSAFE)
      next_mode = sbc_supervisor_pkg::MODE_RESET;
    else if (mode == sbc_supervisor_pkg::MODE_RESET)
    begin
      if (rstCnt == 16'h0000)
        next_mode = sbc_supervisor_pkg::MODE_STANDBY;
    end
    else if (wrMode && (hwdata[1:0] != 2'b00))
      next_mode = wrMode_t;
  end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      mode     <= sbc_supervisor_pkg::MODE_RESET;
      reqMode  <= sbc_supervisor_pkg::MODE_STANDBY;
      tsdLatch <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      if (wrMode && (hwdata[1:0] != 2'b00))
        reqMode <= wrMode_t;
      if (overTemp)
        tsdLatch <= 1'b1;
      else if (tempBelow)
        tsdLatch <= 1'b0;
    end

  // Reset output: cold hold while undervoltage lasts, then counts down
  wire enterReset = (next_mode == sbc_supervisor_pkg::MODE_RESET) && (underVolt || modeChange);
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      rstCnt <= 16'(sbc_supervisor_pkg::COLD_RST_MS);
    else if (enterReset)
      rstCnt <= 16'(sbc_supervisor_pkg::COLD_RST_MS);
    else if (wdError)
      rstCnt <= 16'(sbc_supervisor_pkg::WARM_RST_MS);
    else if (msTick && (rstCnt != 16'h0000))
      rstCnt <= rstCnt - 16'h0001;

  // ----------------------------------------------------------------
  // Sleep-wake error timer
  // ----------------------------------------------------------------
  logic [15:0] sweCnt;
  logic        wake_error_flag;
  wire sweExpire = inStandby && !modeChange && msTick && (sweCnt == 16'(sbc_supervisor_pkg::SWE_TIME_MS - 1));
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      sweCnt <= 16'h0000;
      wake_error_flag  <= 1'b0;
    end
    else
    begin
      if (!inStandby || modeChange)
        sweCnt <= 16'h0000;
      else if (msTick && (sweCnt != 16'(sbc_supervisor_pkg::SWE_TIME_MS)))
        sweCnt <= sweCnt + 16'h0001;
      // Expiry wins over a clear in the same cycle
      if (sweExpire)
        wake_error_flag <= 1'b1;
      else if (wrInt1 && hwdata[sbc_supervisor_pkg::WAKE_ERROR_FLAG_BIT])
        wake_error_flag <= 1'b0;
    end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  sbc_supervisor_pkg::wdCfg_t wdCfg;
  logic        wdArmed;
  logic [14:0] wdCnt;
  logic [3:0]  errCnt;

  // Period in ms; reserved codes give zero, which never expires
  function automatic logic [14:0] wdPeriod(input logic [2:0] tmr, input logic [1:0] pre);
    logic [14:0] base;
    base = 15'h0000;
    unique case (tmr)
      3'b000: base = 15'h0004;
      3'b001: base = 15'h0020;
      3'b010: base = 15'h0080;
      3'b011: base = (pre == 2'b00) ? 15'h0100 : 15'h0080;
      3'b100: base = 15'h0200;
      3'b101: base = 15'h0800;
      3'b110: return (pre == 2'b00) ? 15'h2800 : (pre == 2'b01) ? 15'h4F10 : 15'h0000;
      3'b111: return 15'h0000;
    endcase
    if (tmr == 3'b011)
      return (pre == 2'b11) ? 15'h0300 : 15'(base * ({13'h0000, pre} + 15'h0002));
    return 15'(base * ({13'h0000, pre} + 15'h0001));
  endfunction

  function automatic logic [3:0] errLimit(input logic [1:0] thr);
    return (thr == 2'b01) ? 4'h5 : (thr == 2'b10) ? 4'h9 : 4'h1;
  endfunction

  // Standby falls back to time-out unless autonomous was chosen
  wire sbc_supervisor_pkg::wdType_t effType = (inStandby && (wdCfg.wdType != sbc_supervisor_pkg::WD_AUTO))
                                              ? sbc_supervisor_pkg::WD_TIMEOUT : wdCfg.wdType;
  wire [14:0] period    = wdPeriod(wdCfg.timer, wdCfg.pre);
  wire        windowed  = (effType == sbc_supervisor_pkg::WD_WINDOW) || (effType == sbc_supervisor_pkg::WD_QA);
  wire        openWin   = !windowed || (wdCnt >= (period >> 1));
  wire        trigSeen  = wdArmed && wrTrig;
  wire        goodTrig  = trigSeen && (hwdata[7:0] == sbc_supervisor_pkg::TRIG_KEY) && openWin;
  wire        badTrig   = trigSeen && !goodTrig;
  wire        missed    = wdArmed && !trigSeen && msTick && (period != 15'h0000) && (wdCnt + 15'h0001 >= period);
  wire        errUp     = missed | badTrig;
  wire [3:0]  errNext   = (errCnt == 4'hF) ? errCnt : errCnt + 4'h1;
  wire        errHit    = errUp && (errNext >= errLimit(wdCfg.thr));

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      wdCfg   <= sbc_supervisor_pkg::WD_CFG_RST;
      wdArmed <= 1'b0;
      wdCnt   <= 15'h0000;
      errCnt  <= 4'h0;
      wdError <= 1'b0;
    end
    else
    begin
      if (wrMode)
        wdCfg.enable <= hwdata[sbc_supervisor_pkg::MODE_EN_BIT];
      if (wrCfg1)
      begin
        wdCfg.wdType <= sbc_supervisor_pkg::wdType_t'(hwdata[sbc_supervisor_pkg::WD_TYPE_LSB +: 2]);
        wdCfg.pre    <= hwdata[sbc_supervisor_pkg::WD_PRE_LSB +: 2];
      end
      if (wrCfg2)
      begin
        wdCfg.timer <= hwdata[sbc_supervisor_pkg::WD_TIMER_LSB +: 3];
        wdCfg.thr   <= hwdata[sbc_supervisor_pkg::WD_THR_LSB +: 2];
      end
      if (!wdCfg.enable || !runMode)
        wdArmed <= 1'b0;
      else if (modeChange)
        wdArmed <= 1'b1;
      if (modeChange || trigSeen || missed)
        wdCnt <= 15'h0000;
      else if (wdArmed && msTick)
        wdCnt <= wdCnt + 15'h0001;
      wdError <= errHit;
      if (errHit)
        errCnt <= 4'h0;
      else if (errUp)
        errCnt <= errNext;
      else if (goodTrig && (errCnt != 4'h0))
        errCnt <= errCnt - 4'h1;
    end

  // ----------------------------------------------------------------
  // Read mux and pin outputs
  // ----------------------------------------------------------------
  wire [1:0] errShown = (errCnt > 4'h3) ? 2'b11 : errCnt[1:0];
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (dOk)
      unique case (dIdx)
        sbc_supervisor_pkg::IDX_MODE:    rdMux[7:0] = {wdCfg.enable, mode, tsdLatch, 1'b0, reqMode[1:0]};
        sbc_supervisor_pkg::IDX_WD_CFG1: rdMux[7:0] = {wdCfg.wdType, wdCfg.pre, errShown, 2'b00};
        sbc_supervisor_pkg::IDX_WD_CFG2: rdMux[7:0] = {wdCfg.timer, 3'b000, wdCfg.thr};
        sbc_supervisor_pkg::IDX_INT1:    rdMux[7:0] = {3'b000, wake_error_flag, 4'h0};
        default:                         rdMux = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      txEnable    <= 1'b0;
      rxEnable    <= 1'b0;
      rxdOut      <= 1'b1;
      resetOutLow <= 1'b0;
      resetOutOeN <= 1'b0;
      opMode      <= sbc_supervisor_pkg::MODE_RESET;
    end
    else
    begin
      txEnable    <= (next_mode == sbc_supervisor_pkg::MODE_NORMAL);
      rxEnable    <= (next_mode == sbc_supervisor_pkg::MODE_NORMAL) || (next_mode == sbc_supervisor_pkg::MODE_SILENT);
      rxdOut      <= wake_error_flag ? 1'b0 : (rxEnable ? canRx : 1'b1);
      resetOutOeN <= !((next_mode == sbc_supervisor_pkg::MODE_RESET) || enterReset || wdError
                       || (rstCnt != 16'h0000));
      opMode      <= next_mode;
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence sweFire;
    sweExpire ##1 wake_error_flag;
  endsequence

  a_uv_forces_reset: assert property (underVolt |=> mode == sbc_supervisor_pkg::MODE_RESET)
    else $error("undervoltage did not force reset mode");
  a_ov_forces_failsafe: assert property (!underVolt && overVolt |=> mode == sbc_supervisor_pkg::MODE_FAILSAFE)
    else $error("overvoltage did not force fail-safe");
  a_failsafe_paths_off: assert property (mode == sbc_supervisor_pkg::MODE_FAILSAFE |-> !txEnable && !rxEnable)
    else $error("transceiver paths active in fail-safe");
  a_tsd_hold: assert property (tsdLatch && !tempBelow |=> tsdLatch)
    else $error("thermal fault cleared without falling indication");
  a_swe_flag_rxd: assert property (sweFire |=> !rxdOut && mode == sbc_supervisor_pkg::MODE_STANDBY)
    else $error("wake error did not pull receive pin low");
  a_swe_stopped: assert property (!inStandby |=> sweCnt == 16'h0000)
    else $error("sleep-wake timer ran outside standby");
  a_standby_type: assert property (inStandby && wdCfg.wdType == sbc_supervisor_pkg::WD_WINDOW
                                   |-> !windowed)
    else $error("standby kept window watchdog");
  a_err_up_count: assert property (errUp && !errHit |=> errCnt == $past(errNext))
    else $error("error counter did not increment");
  a_err_floor: assert property (goodTrig && !errUp && errCnt == 4'h0 |=> errCnt == 4'h0)
    else $error("error counter went below zero");
  a_wd_warm_reset: assert property (errHit |=> wdError ##1 !resetOutOeN [*2])
    else $error("watchdog error did not pull reset low");
  a_wd_off_default: assert property (!wdCfg.enable |=> !wdArmed)
    else $error("watchdog armed while disabled");

endmodule

// [test/mcu_pin_model.sv]
// Microcontroller side of the supervisor: CAN controller and serial pins
`timescale 1ns/1ns
module mcu_pin_model
(
  input  wire logic mclk,
  input  wire logic floatPins,
  input  wire logic resetOutLow,
  input  wire logic resetOutOeN,
  output logic      txdPin,
  output logic      serialSelectNPin,
  output logic      sclkPin,
  output logic      canRxPin,
  output logic      resetWire
);
  logic canPattern;

  initial canPattern = 1'b0;

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  // Received bus data changes every cycle so a stale copy shows up
  always @(posedge mclk)
  begin
    canPattern <= ~canPattern;
  end

  // Driven pins sit opposite to their pull, so a released pin is visible
  assign txdPin           = floatPins ? 1'b1 : 1'b0;
  assign serialSelectNPin = floatPins ? 1'b1 : 1'b0;
  assign sclkPin          = floatPins ? 1'b0 : 1'b1;
  assign canRxPin         = canPattern;
  // Open-drain reset line with its pull-up
  assign resetWire        = resetOutOeN ? 1'b1 : resetOutLow;
endmodule

// [test/test_sbc_fault_watchdog_supervisor.sv]
// Self-checking bench for the fault and watchdog supervisor
`timescale 1ns/1ns
module test_sbc_fault_watchdog_supervisor;
  localparam int         TICK = 4;
  localparam int         SLEEP_WAKE_ERROR_TIMER  = sbc_supervisor_pkg::SWE_TIME_MS * TICK;
  localparam int         COLD = sbc_supervisor_pkg::COLD_RST_MS * TICK;
  localparam int         WARM = sbc_supervisor_pkg::WARM_RST_MS * TICK;
  localparam logic [7:0] MODE = sbc_supervisor_pkg::IDX_MODE;
  localparam logic [7:0] CFG1 = sbc_supervisor_pkg::IDX_WD_CFG1;
  localparam logic [7:0] CFG2 = sbc_supervisor_pkg::IDX_WD_CFG2;
  localparam logic [7:0] TRIG = sbc_supervisor_pkg::IDX_WD_TRIG;
  localparam logic [7:0] INT1 = sbc_supervisor_pkg::IDX_INT1;
  localparam logic [2:0] RST  = sbc_supervisor_pkg::MODE_RESET;
  localparam logic [2:0] NORM = sbc_supervisor_pkg::MODE_NORMAL;
  localparam logic [2:0] STBY = sbc_supervisor_pkg::MODE_STANDBY;
  localparam logic [2:0] FSAF = sbc_supervisor_pkg::MODE_FAILSAFE;

  logic                           mclk, resetn, hsel, hwrite, hreadyout, hresp, floatPins, resetWire;
  logic [31:0]                    haddr, hwdata, hrdata, rd;
  logic [1:0]                     htrans;
  logic [2:0]                     hsize;
  logic                           txdPin, serialSelectNPin, sclkPin, canRxPin;
  logic                           txdToCore, serialSelectN, sclkToCore, txEnable, rxEnable;
  logic                           rxdOut, resetOutLow, resetOutOeN;
  sbc_supervisor_pkg::faultPins_t faultPins;
  sbc_supervisor_pkg::opMode_t    opMode;
  int                             nMismatch, testsRun, n;

  sbc_fault_watchdog_supervisor #(.TICK_CYCLES(TICK)) uut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .faultPins(faultPins), .txdPin(txdPin),
    .serialSelectNPin(serialSelectNPin), .sclkPin(sclkPin), .canRxPin(canRxPin), .txdToCore(txdToCore),
    .serialSelectN(serialSelectN), .sclkToCore(sclkToCore), .txEnable(txEnable), .rxEnable(rxEnable),
    .rxdOut(rxdOut), .resetOutLow(resetOutLow), .resetOutOeN(resetOutOeN), .opMode(opMode));

  mcu_pin_model mcu (.mclk(mclk), .floatPins(floatPins), .resetOutLow(resetOutLow),
    .resetOutOeN(resetOutOeN), .txdPin(txdPin), .serialSelectNPin(serialSelectNPin),
    .sclkPin(sclkPin), .canRxPin(canRxPin), .resetWire(resetWire));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic timeout(input string what);
    nMismatch++;
    $display("BAD %0t wait for %s ran out", $time, what);
    final_report();
  endtask

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD %0t %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkRange(input int got, input int lo, input int hi);
    testsRun++;
    if (got < lo || got > hi)
    begin
      nMismatch++;
      $display("BAD %0t interval %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Data phase ends at the rising edge where hready is seen high
  task automatic waitRdy();
    int k;
    k = 0;
    do
    begin
      @(negedge mclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
      timeout("hready");
    rd = hrdata;
    @(posedge mclk);
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    waitRdy();
  endtask

  function automatic logic [2:0] pick(input int sel);
    if (sel == 0)
      return opMode;
    return (sel == 1) ? {2'b00, resetWire} : {2'b00, rxdOut};
  endfunction

  // Counts falling edges until the watched output shows the value
  task automatic waitOn(input int sel, input logic [2:0] v, input int lim);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (pick(sel) !== v && n < lim);
    if (pick(sel) !== v)
      timeout("output");
  endtask

  task automatic setFault(input logic [3:0] f);
    @(posedge mclk);
    faultPins <= f;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    {resetn, hsel, hwrite, htrans, floatPins, faultPins} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'b010;
    {nMismatch, testsRun} = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(negedge mclk);
    chkVal({29'h0000_0000, opMode}, {29'h0000_0000, RST}, "mode");
    chkVal({30'h0000_0000, resetOutOeN, hresp}, 32'h0000_0000, "reset out");
    chkVal({29'h0000_0000, txdToCore, serialSelectN, sclkToCore}, 32'h0000_0001, "pins");
    @(posedge mclk);
    floatPins <= 1'b1;
    repeat (4) @(negedge mclk);
    chkVal({29'h0000_0000, txdToCore, serialSelectN, sclkToCore}, 32'h0000_0006, "pins");
    waitOn(0, STBY, COLD + 20);
    chkRange(n, COLD - 20, COLD + 5);
    $display("Test power-up done");
    bus(TRIG, 1'b1, 8'h00);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_0000, "error count");
    bus(MODE, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0080, 32'h0000_0000, "enable");
    waitOn(2, 3'b000, SLEEP_WAKE_ERROR_TIMER + 50);
    chkRange(n, SLEEP_WAKE_ERROR_TIMER - 25, SLEEP_WAKE_ERROR_TIMER + 5);
    chkVal({29'h0000_0000, opMode}, {29'h0000_0000, STBY}, "mode");
    bus(INT1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0010, 32'h0000_0010, "wake flag");
    bus(INT1, 1'b1, 8'h10);
    bus(MODE, 1'b1, 8'h01);
    repeat (SLEEP_WAKE_ERROR_TIMER + 200) @(negedge mclk);
    chkVal({30'h0000_0000, txEnable, rxEnable}, 32'h0000_0003, "paths");
    // Bus data takes three edges to reach the pin, so it shows the inverse of the toggling model
    chkVal({31'h0000_0000, rxdOut}, {31'h0000_0000, ~canRxPin}, "rx data");
    bus(INT1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0010, 32'h0000_0000, "wake flag");
    bus(MODE, 1'b1, 8'h03);
    waitOn(0, STBY, 10);
    waitOn(2, 3'b000, SLEEP_WAKE_ERROR_TIMER + 50);
    chkRange(n, SLEEP_WAKE_ERROR_TIMER - 25, SLEEP_WAKE_ERROR_TIMER + 5);
    bus(INT1, 1'b1, 8'h10);
    $display("Test sleep-wake done");
    bus(MODE, 1'b1, 8'h01);
    waitOn(0, NORM, 10);
    setFault(4'h8);
    waitOn(0, FSAF, 6);
    chkVal({30'h0000_0000, txEnable, rxEnable}, 32'h0000_0000, "paths");
    setFault(4'h0);
    repeat (30) @(negedge mclk);
    bus(MODE, 1'b1, 8'h01);
    bus(MODE, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0078, 32'h0000_0048, "mode reg");
    setFault(4'h4);
    setFault(4'h0);
    waitOn(0, STBY, COLD + 30);
    setFault(4'h1);
    waitOn(0, FSAF, 6);
    setFault(4'h3);
    waitOn(0, RST, 6);
    repeat (100) @(negedge mclk);
    chkVal({28'h000_0000, opMode, resetOutOeN}, {28'h000_0000, RST, 1'b0}, "held");
    setFault(4'h1);
    waitOn(0, FSAF, 6);
    setFault(4'h2);
    waitOn(0, RST, 6);
    setFault(4'h0);
    repeat (COLD - 10) @(negedge mclk);
    chkVal({28'h000_0000, opMode, resetOutOeN}, {28'h000_0000, RST, 1'b0}, "cold");
    waitOn(0, STBY, 40);
    $display("Test faults done");
    for (int t = 0; t < 4; t++)
    begin
      bus(CFG1, 1'b1, 8'(t << 6));
      bus(CFG1, 1'b0, 8'h00);
      chkVal(rd & 32'h0000_00C0, 32'(t << 6), "type");
    end
    bus(CFG1, 1'b1, 8'h40);
    bus(CFG2, 1'b1, 8'h80);
    // Enable first: the mode change only arms a watchdog that is already enabled
    bus(MODE, 1'b1, 8'h80);
    bus(MODE, 1'b1, 8'h81);
    waitOn(1, 3'b000, 2300);
    chkRange(n, 2000, 2100);
    waitOn(1, 3'b001, WARM + 10);
    chkRange(n, WARM - 4, WARM + 4);
    bus(CFG2, 1'b1, 8'h81);
    bus(TRIG, 1'b1, sbc_supervisor_pkg::TRIG_KEY);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_0000, "error count");
    repeat (3) bus(TRIG, 1'b1, 8'h00);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_000C, "error count");
    bus(TRIG, 1'b1, sbc_supervisor_pkg::TRIG_KEY);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_0008, "error count");
    repeat (2) bus(TRIG, 1'b1, 8'h5A);
    repeat (2) @(negedge mclk);
    chkVal({31'h0000_0000, resetOutOeN}, 32'h0000_0001, "reset out");
    bus(TRIG, 1'b1, 8'h00);
    waitOn(1, 3'b000, 10);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_0000, "error count");
    bus(CFG1, 1'b1, 8'h80);
    bus(TRIG, 1'b1, sbc_supervisor_pkg::TRIG_KEY);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_00CC, 32'h0000_0084, "window");
    bus(MODE, 1'b1, 8'h83);
    bus(TRIG, 1'b1, sbc_supervisor_pkg::TRIG_KEY);
    bus(CFG1, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_000C, 32'h0000_0000, "error count");
    $display("Test watchdog done");
    final_report();
  end
endmodule
